// file: rtl/tsr_pkg.sv
package tsr_pkg;

   // register select codes carried in the low pointer bits
   localparam logic [2:0]  SEL_TEMP  = 3'h0;
   localparam logic [2:0]  SEL_CFG   = 3'h1;
   localparam logic [2:0]  SEL_HYST  = 3'h2;
   localparam logic [2:0]  SEL_TOS   = 3'h3;
   localparam logic [2:0]  SEL_TRIG  = 3'h4;

   // power-up values
   localparam logic [7:0]  PTR_RST   = 8'h00;
   localparam logic [7:0]  CFG_RST   = 8'h00;
   localparam logic [15:0] TEMP_RST  = 16'h0000;
   localparam logic [15:0] HYST_RST  = 16'h4b00;
   localparam logic [15:0] TOS_RST   = 16'h5000;

   // reserved configuration bits read back as zero
   localparam logic [7:0]  CFG_WMASK = 8'h3f;
   // the four fraction-padding bits of a 16-bit word are always zero
   localparam logic [15:0] WORD_MASK = 16'hfff0;
   localparam logic [3:0]  PAD_ZERO  = 4'h0;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;

   // configuration bit positions
   localparam int CFG_SHDN  = 0;
   localparam int CFG_INT   = 1;
   localparam int CFG_POL   = 2;
   localparam int CFG_FQ_LO = 3;
   localparam int CFG_OS    = 5;

   // fault queue depths
   localparam logic [2:0]  FQ_ONE    = 3'h1;
   localparam logic [2:0]  FQ_TWO    = 3'h2;
   localparam logic [2:0]  FQ_FOUR   = 3'h4;
   localparam logic [2:0]  FQ_SIX    = 3'h6;

   // fixed upper four bits of the seven-bit bus address
   localparam logic [3:0]  BUS_ADDR_HI = 4'h9;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [1:0]  IDX_PTR     = 2'h0;
   localparam logic [1:0]  IDX_FIRST   = 2'h1;
   localparam logic [1:0]  IDX_SECOND  = 2'h2;
   localparam logic [1:0]  IDX_LAST    = 2'h3;

   // conversion timing
   localparam int CODE_W         = 12;
   localparam int CONV_PERIOD_MS = 60;
   localparam int CLK_HZ         = 25_000_000;
   localparam int CYC_PER_MS     = CLK_HZ / 1000;

   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_ADDR      = 3'b001,
      ST_ADDR_ACK  = 3'b010,
      ST_WRITE     = 3'b011,
      ST_WRITE_ACK = 3'b100,
      ST_READ      = 3'b101,
      ST_READ_ACK  = 3'b110
   } tsr_bus_st_t;

endpackage

// file: rtl/tsr_sync.sv
`timescale 1ns/1ps
module tsr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   if (W < 1) begin : g_chk
      $error("tsr_sync width must be at least one");
   end

   // two stages; the first is read only by the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule // tsr_sync

// file: rtl/tsr_fault.sv
`timescale 1ns/1ps
module tsr_fault
   import tsr_pkg::*;
#(
   parameter int CW = CODE_W
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_b,
   // new conversion result
   input  wire logic          res_valid,
   input  wire logic [CW-1:0] result,
   // limits and settings
   input  wire logic [CW-1:0] tos_lim,
   input  wire logic [CW-1:0] hyst_lim,
   input  wire logic [1:0]    fq_sel,
   input  wire logic          int_mode,
   input  wire logic          act_high,
   input  wire logic          host_read,
   // open-drain pin drive
   output logic               overtemp_oe
);

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic       active_q;
   logic       below_q;
   logic       rd_seen_q;
   logic       fault_c;
   logic       below_c;
   logic       set_c;
   logic       clr_c;

   if (CW < 2) begin : g_chk
      $error("tsr_fault code width too small");
   end

   function automatic logic [2:0] fq_depth(input logic [1:0] sel);
      case (sel)
         2'b00:   fq_depth = FQ_ONE;
         2'b01:   fq_depth = FQ_TWO;
         2'b10:   fq_depth = FQ_FOUR;
         default: fq_depth = FQ_SIX;
      endcase
   endfunction

   // limits compared as signed codes
   assign fault_c = res_valid && ($signed(result) >= $signed(tos_lim));
   assign below_c = res_valid && ($signed(result) < $signed(hyst_lim));
   // saturate so a long run of faults cannot wrap the count
   assign cnt_d   = !fault_c ? 3'h0 :
                    (cnt_q == FQ_SIX) ? cnt_q : cnt_q + 3'h1;
   assign set_c   = fault_c && (cnt_d >= fq_depth(fq_sel));
   // interrupt mode also waits for a host read
   assign clr_c   = int_mode ?
                    ((rd_seen_q || host_read) && (below_c || below_q)) :
                    below_c;

   // consecutive fault count, updated per result
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 3'h0;
      end else if (res_valid) begin
         cnt_q <= cnt_d;
      end
   end

   // last result below hysteresis, held between results
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         below_q <= 1'b0;
      end else if (res_valid) begin
         below_q <= below_c;
      end
   end

   // alert state; a new fault wins over a release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         active_q <= 1'b0;
      end else if (set_c) begin
         active_q <= 1'b1;
      end else if (clr_c) begin
         active_q <= 1'b0;
      end
   end

   // a read counts only once the alert stands; the read wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_seen_q <= 1'b0;
      end else if (host_read && active_q) begin
         rd_seen_q <= 1'b1;
      end else if (set_c && !active_q || clr_c) begin
         rd_seen_q <= 1'b0;
      end
   end

   // active low pulls the pin when active, active high releases it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overtemp_oe <= 1'b0;
      end else begin
         overtemp_oe <= active_q ^ act_high;
      end
   end

endmodule // tsr_fault

// file: rtl/tsr_top.sv
`timescale 1ns/1ps
// Functional notes
// - non-negative temperature code is degrees Celsius times sixteen.
// - negative code is twelve-bit two's complement, value minus 4096 over 16.
// - setting one-shot bit 5 powers down at once, stops periodic conversion.
// - in one-shot mode a data write to select 4 runs one conversion.
// - a result passing the over-temperature limit counts as a fault.
// - alert asserts only after the configured consecutive faults, bits 3-4.
// - fault field 00/01/10/11 gives one, two, four, six faults.
// - configuration, pointer, trigger are 8-bit; result and limits 16-bit.
// - result register is read-only; configuration and limits read/write.
// - low three pointer bits select the target register.
// - pointer resets to zero, selecting the result register.
// - result, configuration, hysteresis, over-limit take fixed reset values.
// - sixteen-bit words are returned high byte first, then low byte.
// - with one-shot bit clear, convert every 60 ms.
// - bit 2 clear gives active-low alert, set gives active-high.
// - bit 1 clear gives comparator mode, set gives interrupt mode.
// - shutdown bit 0 stops everything but the serial interface; here a trigger write still runs one conversion.
// - comparator mode releases alert once below hysteresis.
// - interrupt mode releases only after a host read and below hysteresis.
// - over-temperature begins when the result reaches the over-limit.
// - result stored left-justified, four low bits always zero.
module tsr_top
   import tsr_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_PERIOD_MS * CYC_PER_MS
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // two-wire serial bus, open drain
   input  wire logic              scl,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   input  wire logic [2:0]        addr_sel,
   // converter back end
   output logic                   adc_pwr,
   output logic                   conv_start,
   input  wire logic              conv_done,
   input  wire logic [CODE_W-1:0] conv_code,
   // over-temperature pin, open drain
   output logic                   overtemp_output,
   output logic                   overtemp_oe
);

   localparam int TMR_W = (CONV_CYC > 1) ? $clog2(CONV_CYC) : 1;
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(CONV_CYC - 1);

   if (CONV_CYC < 2) begin : g_chk
      $error("tsr_top conversion period must be at least two cycles");
   end

   // synchronised pins
   logic [4:0]        pins_s;
   logic              scl_s;
   logic              sda_s;
   logic [2:0]        addr_s;
   logic              scl_prev_q;
   logic              sda_prev_q;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_c;
   logic              stop_c;
   // bus engine
   tsr_bus_st_t       st_q;
   logic [7:0]        shift_q;
   logic [2:0]        bit_cnt_q;
   logic              full_q;
   logic              rw_q;
   logic              nack_q;
   logic              rd_lo_q;
   logic [1:0]        idx_q;
   logic [15:0]       rd_word_q;
   logic [7:0]        rd_next;
   logic              addr_hit;
   logic              addr_done;
   logic              wr_byte;
   logic              host_read;
   // registers
   logic [7:0]        ptr_q;
   logic [2:0]        sel;
   logic [7:0]        cfg_q;
   logic [7:0]        hold_q;
   logic [15:0]       temp_q;
   logic [15:0]       hyst_q;
   logic [15:0]       tos_q;
   logic              trig_c;
   // conversion control
   logic [TMR_W-1:0]  tmr_q;
   logic              normal_c;
   logic              tick_c;
   logic              os_req_c;
   logic              go_c;
   logic              busy_q;
   logic              os_run_q;
   logic              res_valid;

   // word seen by the host for a given select
   function automatic logic [15:0] reg_word(input logic [2:0]  s,
                                            input logic [15:0] t,
                                            input logic [7:0]  c,
                                            input logic [15:0] h,
                                            input logic [15:0] o);
      case (s)
         SEL_TEMP: reg_word = t;
         SEL_CFG:  reg_word = {BYTE_ZERO, c};
         SEL_HYST: reg_word = h;
         SEL_TOS:  reg_word = o;
         default:  reg_word = {BYTE_ZERO, BYTE_ZERO};
      endcase
   endfunction

   function automatic logic is_wide(input logic [2:0] s);
      is_wide = (s == SEL_TEMP) || (s == SEL_HYST) || (s == SEL_TOS);
   endfunction

   tsr_sync #(
      .W (5)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({addr_sel, sda_in, scl}),
      .q     (pins_s)
   );

   assign scl_s  = pins_s[0];
   assign sda_s  = pins_s[1];
   assign addr_s = pins_s[4:2];

   // previous samples for edge and condition detection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_prev_q;
   assign scl_fall = !scl_s && scl_prev_q;
   assign start_c  = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_c   = scl_s && scl_prev_q && !sda_prev_q && sda_s;

   // byte events of the bus engine
   assign addr_hit  = (shift_q[7:1] == {BUS_ADDR_HI, addr_s});
   assign addr_done = (st_q == ST_ADDR) && scl_fall && full_q;
   assign wr_byte   = (st_q == ST_WRITE) && scl_fall && full_q;
   assign host_read = addr_done && addr_hit && shift_q[0];
   // 8-bit registers repeat their byte; wide ones alternate
   assign rd_next   = (is_wide(sel) && rd_lo_q) ? rd_word_q[7:0] :
                      is_wide(sel) ? rd_word_q[15:8] : rd_word_q[7:0];

   // serial bus engine; data moves on the falling clock edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q      <= ST_IDLE;
         shift_q   <= BYTE_ZERO;
         bit_cnt_q <= 3'h0;
         full_q    <= 1'b0;
         rw_q      <= 1'b0;
         nack_q    <= 1'b0;
         rd_lo_q   <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (start_c) begin
         st_q      <= ST_ADDR;
         bit_cnt_q <= 3'h0;
         full_q    <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (stop_c) begin
         st_q      <= ST_IDLE;
         sda_oe    <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_WRITE: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  full_q    <= (bit_cnt_q == BIT_LAST);
               end else if (scl_fall && full_q) begin
                  full_q <= 1'b0;
                  if (st_q == ST_WRITE) begin
                     sda_oe <= 1'b1;
                     st_q   <= ST_WRITE_ACK;
                  end else if (addr_hit) begin
                     sda_oe  <= 1'b1;
                     rw_q    <= shift_q[0];
                     rd_lo_q <= 1'b0;
                     st_q    <= ST_ADDR_ACK;
                  end else begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_WRITE_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 3'h0;
                  if (rw_q) begin
                     shift_q <= rd_next;
                     sda_oe  <= !rd_next[7];
                     rd_lo_q <= !rd_lo_q;
                     st_q    <= ST_READ;
                  end else begin
                     sda_oe <= 1'b0;
                     st_q   <= ST_WRITE;
                  end
               end
            end
            ST_READ: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  full_q    <= (bit_cnt_q == BIT_LAST);
               end else if (scl_fall) begin
                  if (full_q) begin
                     full_q <= 1'b0;
                     sda_oe <= 1'b0;
                     st_q   <= ST_READ_ACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sda_oe  <= !shift_q[6];
                  end
               end
            end
            ST_READ_ACK: begin
               if (scl_rise) begin
                  nack_q <= sda_s;
               end else if (scl_fall) begin
                  // a not-acknowledge ends our part; wait for stop
                  if (nack_q) begin
                     st_q <= ST_IDLE;
                  end else begin
                     shift_q   <= rd_next;
                     sda_oe    <= !rd_next[7];
                     rd_lo_q   <= !rd_lo_q;
                     bit_cnt_q <= 3'h0;
                     st_q      <= ST_READ;
                  end
               end
            end
            default: begin
               st_q   <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   assign sda_out         = 1'b0;
   assign overtemp_output = 1'b0;

   // snapshot at address time so a conversion cannot tear a read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_word_q <= TEMP_RST;
      end else if (host_read) begin
         rd_word_q <= reg_word(sel, temp_q, cfg_q, hyst_q, tos_q);
      end
   end

   // byte position within a write transfer, saturating
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_q <= IDX_PTR;
      end else if (addr_done) begin
         idx_q <= IDX_PTR;
      end else if (wr_byte && idx_q != IDX_LAST) begin
         idx_q <= idx_q + 2'h1;
      end
   end

   // pointer: first byte of every write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= PTR_RST;
      end else if (wr_byte && idx_q == IDX_PTR) begin
         ptr_q <= shift_q;
      end
   end

   assign sel = ptr_q[2:0];

   // configuration; reserved bits kept at zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= CFG_RST;
      end else if (wr_byte && idx_q == IDX_FIRST && sel == SEL_CFG) begin
         cfg_q <= shift_q & CFG_WMASK;
      end
   end

   // limits: high byte held, word committed on the low byte
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= BYTE_ZERO;
         hyst_q <= HYST_RST;
         tos_q  <= TOS_RST;
      end else if (wr_byte) begin
         if (idx_q == IDX_FIRST && is_wide(sel)) begin
            hold_q <= shift_q;
         end
         if (idx_q == IDX_SECOND && sel == SEL_HYST) begin
            hyst_q <= {hold_q, shift_q} & WORD_MASK;
         end
         if (idx_q == IDX_SECOND && sel == SEL_TOS) begin
            tos_q <= {hold_q, shift_q} & WORD_MASK;
         end
      end
   end

   // any data byte to the trigger select; the data is dropped
   assign trig_c   = wr_byte && idx_q != IDX_PTR && sel == SEL_TRIG;

   assign normal_c = !cfg_q[CFG_SHDN] && !cfg_q[CFG_OS];
   assign tick_c   = normal_c && (tmr_q == TMR_LAST);
   assign os_req_c = trig_c && (cfg_q[CFG_OS] || cfg_q[CFG_SHDN]);
   assign go_c     = !busy_q && (tick_c || os_req_c);
   assign res_valid = busy_q && conv_done && (normal_c || os_run_q);

   // period timer, held at zero outside normal mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr_q <= '0;
      end else if (!normal_c || tmr_q == TMR_LAST) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   // conversion in flight; a periodic one is dropped on power-down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q   <= 1'b0;
         os_run_q <= 1'b0;
      end else if (busy_q && conv_done) begin
         busy_q   <= 1'b0;
         os_run_q <= 1'b0;
      end else if (busy_q && !normal_c && !os_run_q) begin
         busy_q <= 1'b0;
      end else if (go_c) begin
         busy_q   <= 1'b1;
         os_run_q <= os_req_c;
      end
   end

   // converter strobe and power request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_start <= 1'b0;
         adc_pwr    <= 1'b0;
      end else begin
         conv_start <= go_c;
         adc_pwr    <= normal_c || os_run_q || os_req_c;
      end
   end

   // result register; codes arrive as two's complement sixteenths
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_q <= TEMP_RST;
      end else if (res_valid) begin
         temp_q <= {conv_code, PAD_ZERO};
      end
   end

   tsr_fault #(
      .CW (CODE_W)
   ) u_fault (
      .clk         (clk),
      .rst_b       (rst_b),
      .res_valid   (res_valid),
      .result      (conv_code),
      .tos_lim     (tos_q[15:4]),
      .hyst_lim    (hyst_q[15:4]),
      .fq_sel      (cfg_q[CFG_FQ_LO +: 2]),
      .int_mode    (cfg_q[CFG_INT]),
      .act_high    (cfg_q[CFG_POL]),
      .host_read   (host_read),
      .overtemp_oe (overtemp_oe)
   );

endmodule // tsr_top

// file: verif/tsr_properties.sv
`timescale 1ns/1ps
module tsr_chk
   import tsr_pkg::*;
(
   // clock and reset
   input wire logic              clk,
   input wire logic              rst_b,
   // bus pins
   input wire logic              scl,
   input wire logic              sda_in,
   input wire logic              sda_out,
   input wire logic              sda_oe,
   input wire logic [2:0]        addr_sel,
   // converter link
   input wire logic              adc_pwr,
   input wire logic              conv_start,
   input wire logic              conv_done,
   input wire logic [CODE_W-1:0] conv_code,
   // alert pin
   input wire logic              overtemp_output,
   input wire logic              overtemp_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [4:0] hi_q;
   // run length of scl high; an idle bus must be left free
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b) hi_q <= 5'h00;
      else hi_q <= !scl ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1f};
   a_sda_drive_low: assert property (sda_out == 1'b0)
      else $error("sda drive level not low");
   a_alert_drive_low: assert property (overtemp_output == 1'b0)
      else $error("alert drive level not low");
   a_idle_bus_free: assert property (hi_q == 5'h10 |-> !sda_oe)
      else $error("sda held on idle bus");
   a_reset_quiet: assert property ($rose(rst_b) |->
      !sda_oe && !conv_start && !overtemp_oe)
      else $error("outputs busy after reset");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   a_start_power: assert property (conv_start |=> adc_pwr)
      else $error("start without power");
   a_done_not_start: assert property (conv_done |-> !conv_start)
      else $error("start while converting");
   a_alert_cause: assert property ($changed(overtemp_oe) |->
      $past(conv_done, 2) or ##[0:12] sda_oe)
      else $error("alert moved without cause");
   c_start: cover property (conv_start);
   c_alert: cover property ($rose(overtemp_oe));
   c_ack: cover property ($rose(sda_oe));
endmodule // tsr_chk
bind tsr_top tsr_chk u_chk (.*);

// file: verif/tsr_host.sv
`timescale 1ns/1ps
module tsr_host (
   // clock
   input wire logic clk,
   // bus pins: scl driven, sda pulled low or released
   output logic     scl,
   output logic     sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // sampled late in the high phase, slave answers lag the pins
   task automatic bitx(input logic b, output logic r);
      sda_low <= !b;
      wt(2);
      scl <= 1'b1;
      wt(3);
      #1 r = sda;
      wt(1);
      scl <= 1'b0;
      wt(2);
   endtask
   task automatic start();
      sda_low <= 1'b1;
      wt(4);
      scl <= 1'b0;
      wt(2);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      wt(2);
      scl <= 1'b1;
      wt(4);
      sda_low <= 1'b0;
      wt(8);
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, ack);
   endtask
endmodule // tsr_host

// file: verif/tsr_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
 n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tsr_top_tb
   import tsr_pkg::*;
;
   localparam int CC = 200;
   logic clk, rst_b, scl, sda_in, sda_out, sda_oe, adc_pwr, conv_start;
   logic conv_done, overtemp_output, overtemp_oe, h_low, a;
   logic [2:0]  addr_sel, pipe;
   logic [7:0]  q;
   logic [11:0] conv_code, code_v;
   logic [15:0] v;
   logic [15:0] rv [4] = '{TEMP_RST, {CFG_RST, CFG_RST}, HYST_RST, TOS_RST};
   logic [11:0] cv [3] = '{12'h190, 12'he70, 12'h7d0};
   logic [31:0] lfsr = 32'h1084_cc43;
   int n_fail, samples_checked, nstart, t0;
   assign sda_in = !(h_low || sda_oe);
   tsr_top #(.CONV_CYC(CC)) dut (.*);
   tsr_host u_host (.clk(clk), .scl(scl), .sda_low(h_low), .sda(sda_in));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int depth(input logic [1:0] f);
      return f == 2'h0 ? 1 : f == 2'h1 ? 2 : f == 2'h2 ? 4 : 6;
   endfunction
   // converter stand-in answers four cycles after a start
   always @(posedge clk) begin
      pipe <= {pipe[1:0], conv_start};
      conv_done <= pipe[2];
      conv_code <= pipe[2] ? code_v : ~code_v;
      if (conv_start === 1'b1) nstart <= nstart + 1;
   end
   task automatic wr(input logic [2:0] s, input int n, input logic [15:0] d);
      u_host.start();
      u_host.xfer({BUS_ADDR_HI, addr_sel, 1'b0}, 1'b1, q, a);
      `CHK("addr ack", 1'b0, a)
      u_host.xfer({5'h00, s}, 1'b1, q, a);
      if (n > 0) u_host.xfer(d[15:8], 1'b1, q, a);
      if (n > 1) u_host.xfer(d[7:0], 1'b1, q, a);
      u_host.stop();
   endtask
   task automatic rdn(output logic [15:0] r);
      u_host.start();
      u_host.xfer({BUS_ADDR_HI, addr_sel, 1'b1}, 1'b1, q, a);
      u_host.xfer(8'hff, 1'b0, r[15:8], a);
      u_host.xfer(8'hff, 1'b1, r[7:0], a);
      u_host.stop();
   endtask
   task automatic rd(input logic [2:0] s, output logic [15:0] r);
      wr(s, 0, 16'h0000);
      rdn(r);
   endtask
   task automatic conv_wait();
      repeat (1000) begin
         @(posedge clk);
         if (conv_done === 1'b1) break;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic idle(input logic [2:0] s, input logic [15:0] d);
      wr(s, 1, d);
      // a trigger start lands inside its own write, so keep that count
      if (s != SEL_TRIG) nstart = 0;
      repeat (3 * CC) @(posedge clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      test_done();
   end
   initial begin
      {rst_b, pipe, conv_done, conv_code, code_v} = '0;
      {n_fail, samples_checked, nstart} = '0;
      addr_sel = lfsr[2:0];
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rdn(v);
      `CHK("pointer reset", TEMP_RST, v)
      for (int i = 0; i < 4; i++) begin
         rd(3'(i), v);
         `CHK("reset value", rv[i], v)
      end
      $display("done reset values");
      lfsr = nxt(lfsr);
      wr(SEL_HYST, 2, lfsr[15:0]);
      wr(SEL_TEMP, 2, lfsr[31:16]);
      wr(SEL_CFG, 1, 16'hff00);
      rd(SEL_HYST, v);
      `CHK("limit rw", lfsr[15:0] & WORD_MASK, v)
      rd(SEL_TEMP, v);
      `CHK("result ro", TEMP_RST, v)
      rd(SEL_CFG, v);
      `CHK("cfg rw", {2{CFG_WMASK}}, v)
      rd(3'h5, v);
      `CHK("unmapped", 16'h0000, v)
      u_host.start();
      u_host.xfer({BUS_ADDR_HI, ~addr_sel, 1'b1}, 1'b1, q, a);
      `CHK("foreign addr", 1'b1, a)
      u_host.stop();
      wr(SEL_CFG, 1, 16'h0000);
      $display("done access");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         code_v = i < 3 ? cv[i] : lfsr[11:0];
         conv_wait();
         rd(SEL_TEMP, v);
         `CHK("temp code", {code_v, 4'h0}, v)
      end
      $display("done encoding");
      wr(SEL_TOS, 2, 16'h1900);
      wr(SEL_HYST, 2, 16'h1400);
      for (int f = 0; f < 4; f++) begin
         code_v = 12'h000;
         wr(SEL_CFG, 1, {3'h0, 2'(f), 11'h000});
         conv_wait();
         code_v = 12'h190; // exactly at the limit
         for (int k = 1; k <= depth(2'(f)); k++) begin
            conv_wait();
            `CHK("fault queue", k >= depth(2'(f)), overtemp_oe)
         end
      end
      code_v = 12'h13f;
      conv_wait();
      `CHK("cmp release", 1'b0, overtemp_oe)
      $display("done fault queue");
      wr(SEL_CFG, 1, 16'h0200);
      code_v = 12'h190;
      conv_wait();
      code_v = 12'h000;
      conv_wait();
      `CHK("int held", 1'b1, overtemp_oe)
      rd(SEL_TEMP, v);
      `CHK("int release", 1'b0, overtemp_oe)
      wr(SEL_CFG, 1, 16'h0400);
      `CHK("polarity", 1'b1, overtemp_oe)
      $display("done alert modes");
      idle(SEL_CFG, 16'h2000);
      `CHK("oneshot idle", 0, nstart)
      `CHK("oneshot power", 1'b0, adc_pwr)
      code_v = 12'h321;
      idle(SEL_TRIG, 16'ha500);
      `CHK("trigger once", 1, nstart)
      rd(SEL_TEMP, v);
      `CHK("oneshot temp", {12'h321, 4'h0}, v)
      idle(SEL_CFG, 16'h0100);
      `CHK("shutdown idle", 0, nstart)
      wr(SEL_CFG, 1, 16'h0000);
      t0 = 0;
      repeat (2 * CC) begin
         @(posedge clk);
         if (conv_start === 1'b1) break;
      end
      repeat (3 * CC) begin
         @(posedge clk);
         t0++;
         if (conv_start === 1'b1) break;
      end
      `CHK("period", CC, t0)
      $display("done power modes");
      test_done();
   end
endmodule // tsr_top_tb
